//--- design/spi_rate_consts.svh
// Purpose: offsets, field positions, reset values and counts for the serial rate/status/data block
// Assumes: wishbone byte addresses, one aligned 32-bit word per register
// Notes:   definitions only
`ifndef SPI_RATE_CONSTS_SVH
`define SPI_RATE_CONSTS_SVH

`define OFS_BIT_RATE_CONFIG  4'h0
`define OFS_SERIAL_STATUS    4'h4
`define OFS_SERIAL_DATA      4'h8
`define OFS_CONTROL          4'hc

`define RATE_PRESCALE_LSB    4
`define RATE_DIVISOR_LSB     0
`define RATE_WRITE_MASK      8'h77

`define STATUS_RX_FULL_BIT   7
`define STATUS_TX_EMPTY_BIT  5
`define STATUS_FAULT_BIT     4

`define CTRL_ENABLE_BIT      0
`define CTRL_MASTER_BIT      1
`define CTRL_FAULT_EN_BIT    2
`define CTRL_SEL_OUT_BIT     3
`define CTRL_TX_IRQ_BIT      4
`define CTRL_WRITE_MASK      8'h1f

`define BIT_RATE_RESET       8'h00
`define CONTROL_RESET        8'h00
`define DATA_RESET           8'h00

`define BITS_PER_FRAME       4'h8

`endif

//--- design/spi_rate_pkg.sv
// Purpose: types for the serial rate/status/data block
// Assumes: constants live in spi_rate_consts.svh
// Notes:   one packed struct carries all state of the block
package spi_rate_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DONE  = 3'b100
    } shift_state_t;

    typedef struct packed {
        logic [7:0]   rate_cfg;
        logic [7:0]   ctrl;
        logic [7:0]   rx_buf;
        logic [7:0]   tx_buf;
        logic         tx_buf_full;
        logic [7:0]   shifter;
        logic [3:0]   bit_cnt;
        shift_state_t state;
        logic         rx_full;
        logic         fault;
        logic         rx_armed;
        logic         tx_armed;
        logic         fault_armed;
        logic [2:0]   pre_cnt;
        logic [7:0]   div_cnt;
        logic         sck;
        logic         ack;
        logic [7:0]   rdata;
        logic         sel_s1;
        logic         sel_s2;
        logic         miso_s1;
        logic         miso_s2;
        logic         done_pulse;
        logic         load_pulse;
    } state_t;

endpackage : spi_rate_pkg

//--- design/spi_rate_status_data.sv
// Purpose: bit-rate generator, status flags and double-buffered data of a serial port
// Assumes: classic wishbone slave, 10 MHz clk_i, synchronous active-high reset
// Notes:   the shifter runs mode 0, msb first, master only; slave side is not built
// Register map, byte offsets on the bus
//   0x0 bit_rate_config, read and write
//   0x4 serial_status, read only
//   0x8 serial_data, read and write
//   0xc first_control_register, read and write
//   other offsets read zero and take no write
//   every access is acknowledged once
//   only byte lane 0 carries register data
//   upper read data bits are always zero
//
// bit_rate_config fields
//   6:4 prescale_select, divide by code plus one
//   2:0 rate_divisor_select, divide by 2 up to 256
//   bits 7 and 3 are masked off on write
//   a change in mid frame may stretch one half
//   period of that frame; later frames are exact
//   reset value is all zeros: fastest rate
//   fastest rate toggles sck on every clock
//
// serial_status fields
//   7 rx_full_flag, a byte waits in the receive buffer
//   5 tx_empty_flag, the transmit buffer has room
//   4 mode_fault_flag, another master was seen
//   6 and 3:0 read zero, writes are ignored
//   tx_empty_flag is the inverse of the
//   buffer-full bit; the write path also
//   needs module_enable and an armed status read
//
// first_control_register fields
//   0 module_enable
//   1 master_select
//   2 fault_detect_enable
//   3 select_output_enable
//   4 tx_empty_irq_enable
//   7:5 read zero and ignore writes
//   any write clears an armed mode fault
//
// Clear sequences
//   a status read arms one clear per flag,
//   and only for a flag seen set in that read
//   rx_full_flag clears on the next data read
//   tx_empty_flag clears on the next data write
//   mode_fault_flag clears on a control write
//   a data write with no armed status read is
//   dropped, so stale software cannot overrun
//   the transmit buffer
//   a fresh status read re-evaluates each arm
//
// Bit-rate generator
//   the prescale counter runs only while shifting
//   the divider counts prescaled ticks to 2^sel-1
//   each sck half period is (pre+1)*2^sel clocks
//   so a full sck period is twice that
//   counters restart at zero for each frame,
//   which keeps the first half period exact
//   the slowest setting gives 2048 clocks per period
//
// Shift engine, mode 0, msb first
//   sck idles low between frames
//   a load presents bit 7 on mosi at once
//   the rising sck edge counts the bit
//   the falling edge shifts in the input and
//   presents the next output bit, so mosi is
//   steady for the whole high phase
//   the input is taken two clocks late through
//   its synchroniser; at the falling edge this
//   still holds the bit of the high phase,
//   but not at the fastest rate, where it is one bit stale
//   eight falling edges end the frame
//   done lasts one clock, then a queued byte
//   loads at once or the engine goes idle
//   slave operation is not built; a cleared
//   master_select only keeps an idle engine from loading
//
// Transmit path
//   a write lands in the transmit buffer
//   an idle engine loads it on the next clock,
//   so tx_empty_flag is back within two cycles
//   a second byte may then wait in the buffer
//   a byte waiting at frame end loads at once
//   with nothing waiting the flag stays set
//
// Receive path
//   a finished frame fills the receive buffer
//   if the buffer is still full the new byte
//   is dropped and rx_overrun_o pulses once
//   the overrun pulse has no status bit;
//   software must read in time
//
// Mode fault
//   the select input is synchronised first
//   low select sets the flag only as master,
//   with fault detect on and select output off
//   the set wins over a clear in the same cycle
//   the flag does not stop the engine; software
//   decides what to do about the other master
//
// Interrupt
//   irq_o is tx_empty_flag and its enable,
//   gated by module_enable as well
//   with the enable clear software polls
//   irq_o is a level, not a pulse
//
// Disable
//   clearing module_enable stops a frame,
//   empties both buffers and the shifter,
//   clears rx_full_flag and leaves the
//   transmit buffer empty, so the flag reads 1
//   rates and control bits are kept
//
// Bus timing
//   a request is taken on the edge where it
//   is seen with ack_o low
//   ack_o and read data follow one clock later
//   ack_o lasts one clock; the master must drop
//   its strobe before a new request is taken
//   reset is synchronous; all state clears
//   and the select synchroniser starts high
`timescale 1ns/1ns
`include "spi_rate_consts.svh"

module spi_rate_status_data #(
    parameter int ADDR_W = 4
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    output logic                   irq_o,
    output logic                   sck_o,
    output logic                   mosi_o,
    input  wire logic              miso_i,
    input  wire logic              slave_sel_n_i,
    output logic                   rx_overrun_o
);

    // refuse an address too narrow for the four register offsets
    if (ADDR_W < 4) begin : g_addr_check
        $error("ADDR_W must be at least 4");
    end

    spi_rate_pkg::state_t cur_ff;
    spi_rate_pkg::state_t nxt_ff;

    logic       req;
    logic [3:0] ofs;
    logic       wr_lane0;
    logic       enabled;
    logic       is_master;
    logic [2:0] pre_sel;
    logic [2:0] div_sel;
    logic [7:0] div_top;
    logic       pre_tick;
    logic       half_tick;
    logic [7:0] status_val;

    // new request only when not already acked, so each access acts once
    assign req       = cyc_i && stb_i && !cur_ff.ack;
    assign ofs       = adr_i[3:0];
    assign wr_lane0  = we_i && sel_i[0];
    assign enabled   = cur_ff.ctrl[`CTRL_ENABLE_BIT];
    assign is_master = cur_ff.ctrl[`CTRL_MASTER_BIT];
    assign pre_sel   = cur_ff.rate_cfg[`RATE_PRESCALE_LSB +: 3];
    assign div_sel   = cur_ff.rate_cfg[`RATE_DIVISOR_LSB +: 3];
    // each sck half period spans 2^sel prescaled ticks, giving 2^(sel+1) in all
    assign div_top   = 8'((9'h001 << div_sel) - 9'h001);
    assign pre_tick  = (cur_ff.pre_cnt == pre_sel);
    assign half_tick = pre_tick && (cur_ff.div_cnt == div_top);

    // unimplemented status bits are tied low
    always_comb begin
        status_val = 8'h00;
        status_val[`STATUS_RX_FULL_BIT]  = cur_ff.rx_full;
        status_val[`STATUS_TX_EMPTY_BIT] = !cur_ff.tx_buf_full;
        status_val[`STATUS_FAULT_BIT]    = cur_ff.fault;
    end

    // interrupt is gated by the enable, so polling works with it clear
    assign irq_o  = enabled && !cur_ff.tx_buf_full && cur_ff.ctrl[`CTRL_TX_IRQ_BIT];
    assign ack_o  = cur_ff.ack;
    assign dat_o  = {24'h000000, cur_ff.rdata};
    assign sck_o  = cur_ff.sck;
    assign mosi_o = cur_ff.shifter[7];

    // all next-state logic of the block
    always_comb begin
        nxt_ff            = cur_ff;
        nxt_ff.ack        = req;
        nxt_ff.done_pulse = 1'b0;
        nxt_ff.load_pulse = 1'b0;
        rx_overrun_o      = 1'b0;
        // pin inputs pass two flops before any use
        nxt_ff.sel_s1  = slave_sel_n_i;
        nxt_ff.sel_s2  = cur_ff.sel_s1;
        nxt_ff.miso_s1 = miso_i;
        nxt_ff.miso_s2 = cur_ff.miso_s1;

        // register reads
        if (req && !we_i) begin
            case (ofs)
                `OFS_BIT_RATE_CONFIG: nxt_ff.rdata = cur_ff.rate_cfg;
                `OFS_SERIAL_STATUS: begin
                    nxt_ff.rdata = status_val;
                    // arm each clear sequence only for a flag seen set
                    nxt_ff.rx_armed    = cur_ff.rx_full;
                    nxt_ff.tx_armed    = !cur_ff.tx_buf_full;
                    nxt_ff.fault_armed = cur_ff.fault;
                end
                `OFS_SERIAL_DATA: begin
                    nxt_ff.rdata = cur_ff.rx_buf;
                    if (cur_ff.rx_armed) begin
                        nxt_ff.rx_full  = 1'b0;
                        nxt_ff.rx_armed = 1'b0;
                    end
                end
                `OFS_CONTROL: nxt_ff.rdata = cur_ff.ctrl;
                default: nxt_ff.rdata = 8'h00;
            endcase
        end

        // register writes; status offset takes none
        if (req && wr_lane0) begin
            case (ofs)
                `OFS_BIT_RATE_CONFIG: begin
                    nxt_ff.rate_cfg = dat_i[7:0] & `RATE_WRITE_MASK;
                end
                `OFS_SERIAL_DATA: begin
                    // a write not preceded by the status read is dropped
                    if (cur_ff.tx_armed && !cur_ff.tx_buf_full && enabled) begin
                        nxt_ff.tx_buf      = dat_i[7:0];
                        nxt_ff.tx_buf_full = 1'b1;
                        nxt_ff.tx_armed    = 1'b0;
                    end
                end
                `OFS_CONTROL: begin
                    nxt_ff.ctrl = dat_i[7:0] & `CTRL_WRITE_MASK;
                    if (cur_ff.fault_armed) begin
                        nxt_ff.fault       = 1'b0;
                        nxt_ff.fault_armed = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // mode fault sampling, set wins over the clear above
        if (enabled && is_master && cur_ff.ctrl[`CTRL_FAULT_EN_BIT]
            && !cur_ff.ctrl[`CTRL_SEL_OUT_BIT] && !cur_ff.sel_s2) begin
            nxt_ff.fault = 1'b1;
        end

        // rate generator free runs only while a frame is shifting
        if (cur_ff.state == spi_rate_pkg::ST_SHIFT) begin
            nxt_ff.pre_cnt = pre_tick ? 3'h0 : cur_ff.pre_cnt + 3'h1;
            if (pre_tick) begin
                nxt_ff.div_cnt = (cur_ff.div_cnt == div_top) ? 8'h00
                                                              : cur_ff.div_cnt + 8'h01;
            end
        end else begin
            nxt_ff.pre_cnt = 3'h0;
            nxt_ff.div_cnt = 8'h00;
        end

        // shift engine
        case (cur_ff.state)
            spi_rate_pkg::ST_IDLE: begin
                nxt_ff.sck = 1'b0;
                // idle load happens one cycle after the write lands
                if (enabled && is_master && cur_ff.tx_buf_full) begin
                    nxt_ff.shifter     = cur_ff.tx_buf;
                    nxt_ff.tx_buf_full = 1'b0;
                    nxt_ff.load_pulse  = 1'b1;
                    nxt_ff.bit_cnt     = 4'h0;
                    nxt_ff.state       = spi_rate_pkg::ST_SHIFT;
                end
            end
            spi_rate_pkg::ST_SHIFT: begin
                if (half_tick) begin
                    nxt_ff.sck = !cur_ff.sck;
                    if (!cur_ff.sck) begin
                        // rising edge: count the bit; mosi must stay put here
                        nxt_ff.bit_cnt = cur_ff.bit_cnt + 4'h1;
                    end else begin
                        // falling edge: take the input and present the next bit
                        nxt_ff.shifter = {cur_ff.shifter[6:0], cur_ff.miso_s2};
                        if (cur_ff.bit_cnt == `BITS_PER_FRAME) begin
                            nxt_ff.state = spi_rate_pkg::ST_DONE;
                        end
                    end
                end
            end
            spi_rate_pkg::ST_DONE: begin
                nxt_ff.done_pulse = 1'b1;
                if (cur_ff.rx_full) begin
                    rx_overrun_o = 1'b1;
                end else begin
                    nxt_ff.rx_buf  = cur_ff.shifter;
                    nxt_ff.rx_full = 1'b1;
                end
                if (cur_ff.tx_buf_full) begin
                    nxt_ff.shifter     = cur_ff.tx_buf;
                    nxt_ff.tx_buf_full = 1'b0;
                    nxt_ff.load_pulse  = 1'b1;
                    nxt_ff.bit_cnt     = 4'h0;
                    nxt_ff.state       = spi_rate_pkg::ST_SHIFT;
                end else begin
                    nxt_ff.state = spi_rate_pkg::ST_IDLE;
                end
            end
            default: nxt_ff.state = spi_rate_pkg::ST_IDLE;
        endcase

        // disable clears the frame, both buffers and rx flag; registers and the fault flag persist
        if (!enabled) begin
            nxt_ff.state       = spi_rate_pkg::ST_IDLE;
            nxt_ff.tx_buf_full = 1'b0;
            nxt_ff.rx_full     = 1'b0;
            nxt_ff.rx_armed    = 1'b0;
            nxt_ff.tx_buf      = 8'h00;
            nxt_ff.rx_buf      = 8'h00;
            nxt_ff.shifter     = 8'h00;
            nxt_ff.bit_cnt     = 4'h0;
            nxt_ff.sck         = 1'b0;
        end
    end

    // single state register; reset returns every field to a constant
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_ff          <= '0;
            cur_ff.rate_cfg <= `BIT_RATE_RESET;
            cur_ff.ctrl     <= `CONTROL_RESET;
            cur_ff.rx_buf   <= `DATA_RESET;
            cur_ff.state    <= spi_rate_pkg::ST_IDLE;
            cur_ff.sel_s1   <= 1'b1;
            cur_ff.sel_s2   <= 1'b1;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

endmodule : spi_rate_status_data

//--- tb/spi_rate_props.sv
// Purpose: port-level checks of the serial rate/status/data block
// Assumes: one clock, synchronous active-high reset, registered bus answer
// Notes:   attached by bind below
`timescale 1ns/1ns
`include "spi_rate_consts.svh"
module spi_rate_props #(
    parameter int ADDR_W = 4
) (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              cyc_i,
    input wire logic              stb_i,
    input wire logic              we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0]        sel_i,
    input wire logic [31:0]       dat_i,
    input wire logic [31:0]       dat_o,
    input wire logic              ack_o,
    input wire logic              irq_o,
    input wire logic              sck_o,
    input wire logic              mosi_o,
    input wire logic              miso_i,
    input wire logic              slave_sel_n_i,
    input wire logic              rx_overrun_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // read request taken at this edge, split by register
    logic rd_take;
    logic rd_stat;
    logic rd_rate;
    assign rd_take = cyc_i && stb_i && !ack_o && !we_i;
    assign rd_stat = rd_take && (adr_i == `OFS_SERIAL_STATUS);
    assign rd_rate = rd_take && (adr_i == `OFS_BIT_RATE_CONFIG);

    chk_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not answered in one cycle");
    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_status_unused: assert property (rd_stat |=> dat_o[6] == 1'b0 && dat_o[3:0] == 4'h0)
        else $error("unused status bits not zero");
    chk_rate_unused: assert property (rd_rate |=> dat_o[7] == 1'b0 && dat_o[3] == 1'b0)
        else $error("unused rate bits not zero");
    chk_irq_means_empty: assert property (rd_stat && irq_o |=> dat_o[5])
        else $error("irq without tx empty flag");
    chk_mosi_held_high: assert property (sck_o && $past(sck_o) |-> $stable(mosi_o))
        else $error("mosi moved while sck high");
    chk_overrun_pulse: assert property (rx_overrun_o |=> !rx_overrun_o)
        else $error("overrun longer than one cycle");
    chk_data_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("upper read data not zero");
endmodule : spi_rate_props

bind spi_rate_status_data spi_rate_props #(.ADDR_W(ADDR_W)) props (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .irq_o(irq_o), .sck_o(sck_o), .mosi_o(mosi_o), .miso_i(miso_i),
    .slave_sel_n_i(slave_sel_n_i), .rx_overrun_o(rx_overrun_o));

//--- tb/spi_slave_model.sv
// Purpose: behavioural serial peripheral on the far side of the shifter
// Assumes: mode 0, msb first; always selected, no select line exists
// Notes:   sends a byte that steps by one each frame
`timescale 1ns/1ns
module spi_slave_model (
    input  wire logic  sck_i,
    input  wire logic  mosi_i,
    output logic       miso_o,
    output logic [7:0] rx_o,
    output int         frames_o
);
    logic [7:0] tx = 8'ha5;
    logic [7:0] sh = 8'h00;
    int         cnt = 0;
    initial frames_o = 0;
    initial rx_o = 8'h00;
    initial miso_o = 1'b1;
    // sample on the rising edge; eight bits close a frame
    always @(posedge sck_i) begin
        sh = {sh[6:0], mosi_i};
        cnt = (cnt + 1) % 8;
        if (cnt == 0) begin
            rx_o = sh;
            frames_o = frames_o + 1;
            tx = tx + 8'h01;
        end
    end
    // next bit leaves on the falling edge so it is settled before the next rise
    always @(negedge sck_i) miso_o = tx[3'(7 - cnt)];
endmodule : spi_slave_model

//--- tb/testbench.sv
// Purpose: register-level tests of the serial rate/status/data block
// Assumes: classic wishbone, 10 MHz clock, sync reset held 12 cycles
// Notes:   the slave model returns a5, a6, ... one byte per frame
`timescale 1ns/1ns
`include "spi_rate_consts.svh"
module testbench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic        ss_n  = 1'b1;
    logic [3:0]  adr_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o, irq_o, sck_o, mosi_o, miso, ovr;
    logic [7:0]  slv_rx, rd;
    int          frames, f0, fail_count = 0, n_tests = 0, ovr_seen = 0;
    // 100 ns clock
    always #50 clk_i = ~clk_i;
    spi_rate_status_data uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .irq_o(irq_o), .sck_o(sck_o), .mosi_o(mosi_o), .miso_i(miso), .slave_sel_n_i(ss_n),
        .rx_overrun_o(ovr));
    spi_slave_model slave (.sck_i(sck_o), .mosi_i(mosi_o), .miso_o(miso), .rx_o(slv_rx),
        .frames_o(frames));
    // overrun is a one-cycle pulse, so count it at every falling clock edge
    always @(negedge clk_i) if (ovr === 1'b1) ovr_seen++;

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one classic cycle; ack and data are read settled, just before their sampling edge
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                      output logic [7:0] q);
        int t;
        t = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        do begin @(negedge clk_i); t++; end while (ack_o !== 1'b1 && t < 50);
        q = dat_o[7:0];
        if (t >= 50) fail_count++;
        @(posedge clk_i);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string what);
        wb(1'b0, a, 8'h00, rd);
        check(what, exp, rd);
    endtask : rdc
    // frame end plus time for the receive flag to settle
    task automatic wait_frames(input int n);
        int t;
        t = 0;
        while (frames < n && t < 5000) begin @(posedge clk_i); t++; end
        if (t >= 5000) fail_count++;
        repeat (60) @(posedge clk_i);
    endtask : wait_frames
    // start one frame and time how long sck stays high
    task automatic meas(input logic [7:0] cfg, input logic [7:0] half);
        int t;
        int f;
        f = frames;
        wb(1'b1, `OFS_BIT_RATE_CONFIG, cfg, rd);
        wb(1'b0, `OFS_SERIAL_STATUS, 8'h00, rd);
        wb(1'b1, `OFS_SERIAL_DATA, 8'h55, rd);
        t = 0;
        while (sck_o !== 1'b1 && t < 300) begin @(negedge clk_i); t++; end
        t = 0;
        while (sck_o === 1'b1 && t < 300) begin @(negedge clk_i); t++; end
        check("sck half period", half, t[7:0]);
        wait_frames(f + 1);
    endtask : meas
    task automatic wrap_up();
        if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    // watchdog well beyond the expected run
    initial begin
        #5000000;
        fail_count++;
        wrap_up();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc(`OFS_SERIAL_DATA, 8'h00, "data reset");
        rdc(`OFS_SERIAL_STATUS, 8'h20, "status reset");
        wb(1'b1, `OFS_BIT_RATE_CONFIG, 8'hff, rd);
        rdc(`OFS_BIT_RATE_CONFIG, 8'h77, "rate readback");
        wb(1'b1, `OFS_SERIAL_STATUS, 8'hff, rd);
        rdc(`OFS_SERIAL_STATUS, 8'h20, "status write");
        rdc(4'h2, 8'h00, "unmapped read");
        wb(1'b1, `OFS_CONTROL, 8'h13, rd);
        check("irq enabled", 8'h01, {7'h0, irq_o});
        wb(1'b1, `OFS_CONTROL, 8'h03, rd);
        check("irq masked", 8'h00, {7'h0, irq_o});
        meas(8'h00, 8'd1);
        meas(8'h21, 8'd6);
        meas(8'h13, 8'd16);
        rdc(`OFS_SERIAL_STATUS, 8'ha0, "flags after frames");
        wb(1'b1, `OFS_CONTROL, 8'h00, rd);
        rdc(`OFS_SERIAL_STATUS, 8'h20, "flags after disable");
        wb(1'b1, `OFS_BIT_RATE_CONFIG, 8'h21, rd);
        wb(1'b1, `OFS_CONTROL, 8'h03, rd);
        f0 = frames;
        ovr_seen = 0;
        wb(1'b0, `OFS_SERIAL_STATUS, 8'h00, rd);
        wb(1'b1, `OFS_SERIAL_DATA, 8'h3c, rd);
        rdc(`OFS_SERIAL_STATUS, 8'h20, "empty after load");
        wb(1'b1, `OFS_SERIAL_DATA, 8'hc3, rd);
        wb(1'b1, `OFS_SERIAL_DATA, 8'h99, rd);
        wait_frames(f0 + 2);
        repeat (200) @(posedge clk_i);
        check("frame count", 8'd2, 8'(frames - f0));
        check("last byte sent", 8'hc3, slv_rx);
        check("overrun pulses", 8'd1, ovr_seen[7:0]);
        rdc(`OFS_SERIAL_STATUS, 8'ha0, "rx full");
        rdc(`OFS_SERIAL_DATA, 8'ha8, "kept byte");
        rdc(`OFS_SERIAL_STATUS, 8'h20, "rx full cleared");
        wb(1'b1, `OFS_CONTROL, 8'h07, rd);
        ss_n <= 1'b0;
        repeat (4) @(posedge clk_i);
        ss_n <= 1'b1;
        rdc(`OFS_SERIAL_STATUS, 8'h30, "fault set");
        wb(1'b1, `OFS_CONTROL, 8'h0f, rd);
        ss_n <= 1'b0;
        repeat (4) @(posedge clk_i);
        rdc(`OFS_SERIAL_STATUS, 8'h20, "fault with select output");
        ss_n <= 1'b1;
        wb(1'b0, `OFS_SERIAL_STATUS, 8'h00, rd);
        wb(1'b1, `OFS_SERIAL_DATA, 8'h81, rd);
        repeat (20) @(posedge clk_i);
        wb(1'b1, `OFS_CONTROL, 8'h00, rd);
        rdc(`OFS_SERIAL_STATUS, 8'h20, "abort mid frame");
        wrap_up();
    end
endmodule : testbench
